// ### rtl/srbd_pkg.sv
package srbd_pkg;

  // ****************************************************************
  // Geometry of the register chain
  // ****************************************************************
  localparam int unsigned FIELD_COUNT = 8;
  localparam int unsigned WORD_WIDTH  = 32;

  // ****************************************************************
  // APB register map (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_WIDTH  = 12;
  localparam int unsigned DATA_WIDTH  = 32;

  localparam logic [11:0] CTRL_OFFSET      = 12'h000;
  localparam logic [11:0] STATUS_OFFSET    = 12'h004;
  localparam logic [11:0] SHIFT_CNT_OFFSET = 12'h008;
  localparam logic [11:0] WORD_BASE_OFFSET = 12'h020;
  localparam logic [11:0] WORD_LAST_OFFSET = 12'h03C;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CTRL_FORMAT_BIT     = 0;
  localparam int unsigned STATUS_BITS_LSB     = 0;
  localparam int unsigned STATUS_ENABLE_BIT   = 8;
  localparam int unsigned STATUS_FORMAT_BIT   = 9;
  localparam int unsigned WORD_INDEX_LSB      = 2;
  localparam int unsigned WORD_INDEX_WIDTH    = 3;

  localparam logic        FORMAT_RESET        = 1'b0;
  localparam logic [31:0] ZERO_WORD           = 32'h0000_0000;
  localparam logic [15:0] SHIFT_CNT_RESET     = 16'h0000;
  localparam logic [15:0] SHIFT_CNT_STEP      = 16'h0001;

  // ****************************************************************
  // Data format selection
  // ****************************************************************
  typedef enum logic {
    SRBD_FMT_BIT    = 1'b0,
    SRBD_FMT_WORD32 = 1'b1
  } srbd_format_type;

endpackage

// ### rtl/srbd_shift_chain.sv
`timescale 1ns/1ps

// Chain of storage fields that shifts one place either way. Index 0 is
// field 1, index N-1 is field 8. Clear wins over any shift; the caller
// guarantees that fwd_shift and bwd_shift are never high together.
module srbd_shift_chain #(
  parameter int unsigned W = 32,
  parameter int unsigned N = 8
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clear,
  input  wire logic                fwd_shift,
  input  wire logic                bwd_shift,
  input  wire logic [W-1:0]        fwd_in,
  input  wire logic [W-1:0]        bwd_in,
  output logic      [N-1:0][W-1:0] fields_q
);

  // ****************************************************************
  // One generate branch per field
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_field
      logic [W-1:0] fwd_src;
      logic [W-1:0] bwd_src;

      // [R06] Forward source.
      if (i == 0) begin : g_first
        assign fwd_src = fwd_in;
      end else begin : g_fmid
        assign fwd_src = fields_q[i-1];
      end

      // [R07] Backward source.
      if (i == N - 1) begin : g_last
        assign bwd_src = bwd_in;
      end else begin : g_bmid
        assign bwd_src = fields_q[i+1];
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fields_q[i] <= '0;
        // [R09] Clear all fields.
        end else if (clear) begin
          fields_q[i] <= '0;
        // [R08] End field dropped.
        end else if (fwd_shift) begin
          fields_q[i] <= fwd_src;
        end else if (bwd_shift) begin
          fields_q[i] <= bwd_src;
        end
      end
    end
  endgenerate

endmodule

// ### rtl/srbd_shift_register.sv
`timescale 1ns/1ps

// What this block does
// [R01] Disabled block ignores pulses, data and clear.
// [R02] Bit format: forward pulse loads forward bit.
// [R03] Word format: forward pulse loads forward word.
// [R04] Bit format: backward pulse loads backward bit.
// [R05] Word format: backward pulse loads backward word.
// [R06] Forward shift moves fields to higher index.
// [R07] Backward shift moves fields to lower index.
// [R08] Far end field is discarded each shift.
// [R09] Enabled clear zeroes every field.
// [R10] Eight status outputs follow the bit fields.
// [R11] Word format uses only word inputs, outputs.
// [R12] Word data is signed 32-bit.
// [R13] Format defaults to bit after reset.
// [R14] Bit format: word ports have no effect.
// [R15] Exactly one shift per pulse.
// [R16] Pulses act on rising edge only.
// [R17] Clear beats shift; both pulses cancel.
module srbd_shift_register
  import srbd_pkg::*;
#(
  parameter int unsigned NFIELD = srbd_pkg::FIELD_COUNT,
  parameter int unsigned WWIDTH = srbd_pkg::WORD_WIDTH
) (
  input  wire logic                                   pclk,
  input  wire logic                                   presetn,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic        [srbd_pkg::ADDR_WIDTH-1:0] paddr,
  input  wire logic        [srbd_pkg::DATA_WIDTH-1:0] pwdata,
  output logic             [srbd_pkg::DATA_WIDTH-1:0] prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  input  wire logic                                   block_enable_coil,
  input  wire logic                                   forward_pulse_coil,
  input  wire logic                                   backward_pulse_coil,
  input  wire logic                                   clear_coil,
  input  wire logic                                   forward_data_bit,
  input  wire logic                                   backward_data_bit,
  input  wire logic signed [WWIDTH-1:0]               forward_word_in,
  input  wire logic signed [WWIDTH-1:0]               backward_word_in,
  output logic             [NFIELD-1:0]               bit_field_status,
  output logic             [NFIELD-1:0][WWIDTH-1:0]   word_field_out
);

  import srbd_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  srbd_format_type         format_q;
  logic                    fwd_prev_q;
  logic                    bwd_prev_q;
  logic [15:0]             shift_cnt_q;
  logic [15:0]             shift_cnt_d;
  logic [31:0]             prdata_q;
  logic [31:0]             prdata_d;
  logic                    pready_q;
  logic                    pslverr_q;
  logic                    pslverr_d;

  logic                    setup_phase;
  logic                    write_commit;
  logic                    ctrl_write;
  srbd_format_type         format_d;
  logic                    format_change;
  logic                    fwd_edge;
  logic                    bwd_edge;
  logic                    clear_active;
  logic                    chain_clear;
  logic                    do_fwd;
  logic                    do_bwd;
  logic                    bit_fwd;
  logic                    bit_bwd;
  logic                    word_fwd;
  logic                    word_bwd;
  logic [NFIELD-1:0][0:0]  bit_fields;
  logic [WORD_INDEX_WIDTH-1:0] word_index;
  logic                    hit_ctrl;
  logic                    hit_status;
  logic                    hit_count;
  logic                    hit_word;

  // ****************************************************************
  // APB handshake
  // ****************************************************************
  // Every access has one wait-free access phase: the answer is prepared
  // in the setup cycle so that pready and prdata leave flip-flops.
  assign setup_phase  = psel && !penable;
  assign write_commit = psel && penable && pready_q && pwrite && !pslverr_q;
  assign ctrl_write   = write_commit && (paddr == CTRL_OFFSET);
  assign word_index   = paddr[WORD_INDEX_LSB +: WORD_INDEX_WIDTH];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup_phase;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // One select per register, and one for all word fields. A word field is hit only by an aligned
  // address inside its window, so a stray byte address is refused.
  always_comb begin
    hit_ctrl   = 1'b0;
    hit_status = 1'b0;
    hit_count  = 1'b0;
    hit_word   = 1'b0;
    if (paddr == CTRL_OFFSET) begin
      hit_ctrl = 1'b1;
    end else if (paddr == STATUS_OFFSET) begin
      hit_status = 1'b1;
    end else if (paddr == SHIFT_CNT_OFFSET) begin
      hit_count = 1'b1;
    end else if ((paddr >= WORD_BASE_OFFSET) && (paddr <= WORD_LAST_OFFSET)
                 && (paddr[1:0] == 2'b00)) begin
      hit_word = 1'b1;
    end
  end

  // Read data and error decision for the access that follows. Only the
  // control register takes writes; the others are read-only views of
  // the chains, and a write to them is refused rather than dropped.
  always_comb begin
    prdata_d  = ZERO_WORD;
    pslverr_d = 1'b0;
    if (hit_ctrl) begin
      prdata_d[CTRL_FORMAT_BIT] = format_q;
    end else if (hit_status) begin
      prdata_d[STATUS_BITS_LSB +: NFIELD] = bit_field_status;
      prdata_d[STATUS_ENABLE_BIT]         = block_enable_coil;
      prdata_d[STATUS_FORMAT_BIT]         = format_q;
      pslverr_d                           = pwrite;
    end else if (hit_count) begin
      prdata_d[$bits(shift_cnt_q)-1:0] = shift_cnt_q;
      pslverr_d                        = pwrite;
    end else if (hit_word) begin
      prdata_d  = word_field_out[word_index];
      pslverr_d = pwrite;
    end else begin
      pslverr_d = 1'b1;
    end
    if (pwrite) begin
      prdata_d = ZERO_WORD;
    end
  end

  // Read data is shown only in the access phase; between transfers the
  // bus reads zero, so a master that samples late cannot pass by luck.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= ZERO_WORD;
    end else if (setup_phase) begin
      prdata_q <= prdata_d;
    end else begin
      prdata_q <= ZERO_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      pslverr_q <= pslverr_d;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ****************************************************************
  // Data format selection
  // ****************************************************************
  assign format_d      = srbd_format_type'(pwdata[CTRL_FORMAT_BIT]);
  assign format_change = ctrl_write && (format_d != format_q);

  // [R13] Bit format default.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      format_q <= srbd_format_type'(FORMAT_RESET);
    end else if (ctrl_write) begin
      format_q <= format_d;
    end
  end

  // ****************************************************************
  // Coil evaluation
  // ****************************************************************
  // The previous coil levels are tracked even while disabled, so a coil
  // already high when the block is enabled does not count as a pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_prev_q <= 1'b0;
      bwd_prev_q <= 1'b0;
    end else begin
      fwd_prev_q <= forward_pulse_coil;
      bwd_prev_q <= backward_pulse_coil;
    end
  end

  // [R16] Rising edge detect.
  // [R01] Gated by enable.
  assign fwd_edge     = block_enable_coil && forward_pulse_coil && !fwd_prev_q;
  assign bwd_edge     = block_enable_coil && backward_pulse_coil && !bwd_prev_q;
  // [R09] Clear while enabled.
  assign clear_active = block_enable_coil && clear_coil;
  // A format switch empties both chains so neither shows stale data.
  assign chain_clear  = clear_active || format_change;

  // [R17] Clear first, pulses cancel.
  // [R15] One shift per edge.
  assign do_fwd = fwd_edge && !bwd_edge && !chain_clear;
  assign do_bwd = bwd_edge && !fwd_edge && !chain_clear;

  // [R14] Word chain idle in bit format.
  // [R11] Bit chain idle in word format.
  assign bit_fwd  = do_fwd && (format_q == SRBD_FMT_BIT);
  assign bit_bwd  = do_bwd && (format_q == SRBD_FMT_BIT);
  assign word_fwd = do_fwd && (format_q == SRBD_FMT_WORD32);
  assign word_bwd = do_bwd && (format_q == SRBD_FMT_WORD32);

  // ****************************************************************
  // Shift counter, visible to software
  // ****************************************************************
  // Only performed shifts count; refused pulses and clears leave it.
  // It wraps at its width, so software should compare differences.
  always_comb begin
    shift_cnt_d = shift_cnt_q;
    if (do_fwd || do_bwd) begin
      shift_cnt_d = shift_cnt_q + SHIFT_CNT_STEP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_cnt_q <= SHIFT_CNT_RESET;
    end else begin
      shift_cnt_q <= shift_cnt_d;
    end
  end

  // ****************************************************************
  // Storage chains
  // ****************************************************************
  // Two separate chains keep each format's contents apart; a format
  // switch clears both, so neither side ever shows stale data.
  // [R02] [R04] Bit data entry.
  srbd_shift_chain #(
    .W (1),
    .N (NFIELD)
  ) u_bit_chain (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (chain_clear),
    .fwd_shift (bit_fwd),
    .bwd_shift (bit_bwd),
    .fwd_in    (forward_data_bit),
    .bwd_in    (backward_data_bit),
    .fields_q  (bit_fields)
  );

  // [R03] [R05] Word data entry.
  // [R12] Full signed word kept.
  srbd_shift_chain #(
    .W (WWIDTH),
    .N (NFIELD)
  ) u_word_chain (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (chain_clear),
    .fwd_shift (word_fwd),
    .bwd_shift (word_bwd),
    .fwd_in    (forward_word_in),
    .bwd_in    (backward_word_in),
    .fields_q  (word_field_out)
  );

  // ****************************************************************
  // Contact outputs
  // ****************************************************************
  // [R10] Contacts follow bit fields.
  genvar f;
  generate
    for (f = 0; f < NFIELD; f++) begin : g_contact
      assign bit_field_status[f] = bit_fields[f][0];
    end
  endgenerate

endmodule

// ### testbench/srbd_shift_register_monitor.sv
`timescale 1ns/1ps

module srbd_shift_register_monitor
  import srbd_pkg::*;
#(
  parameter int unsigned NFIELD = FIELD_COUNT,
  parameter int unsigned WWIDTH = WORD_WIDTH
) (
  input wire logic                              pclk,
  input wire logic                              presetn,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [srbd_pkg::ADDR_WIDTH-1:0]   paddr,
  input wire logic [srbd_pkg::DATA_WIDTH-1:0]   pwdata,
  input wire logic                              pready,
  input wire logic                              block_enable_coil,
  input wire logic                              forward_pulse_coil,
  input wire logic                              backward_pulse_coil,
  input wire logic                              clear_coil,
  input wire logic                              forward_data_bit,
  input wire logic                              backward_data_bit,
  input wire logic signed [WWIDTH-1:0]          forward_word_in,
  input wire logic signed [WWIDTH-1:0]          backward_word_in,
  input wire logic [NFIELD-1:0]                 bit_field_status,
  input wire logic [NFIELD-1:0][WWIDTH-1:0]     word_field_out
);
  logic fp_q;
  logic bp_q;
  logic fmt_q;
  logic fe;
  logic be;
  logic wr;
  logic go;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  assign fe = forward_pulse_coil & ~fp_q;
  assign be = backward_pulse_coil & ~bp_q;
  assign wr = psel & penable & pready & pwrite & (paddr == CTRL_OFFSET);
  assign go = block_enable_coil & (fe ^ be) & ~clear_coil & ~(wr & (pwdata[0] ^ fmt_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fp_q <= 1'h0;
      bp_q <= 1'h0;
    end else begin
      fp_q <= forward_pulse_coil;
      bp_q <= backward_pulse_coil;
    end
  end

  // A mirror of the format bit, so the checks know which chain is live.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q <= 1'h0;
    end else if (wr) begin
      fmt_q <= pwdata[0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_fb;
    go && fe && !fmt_q |=> bit_field_status ==
      {$past(bit_field_status[NFIELD-2:0]), $past(forward_data_bit)};
  endproperty
  a_fb: assert property (p_fb) else $error("forward bit shift wrong");
  property p_bb;
    go && be && !fmt_q |=> bit_field_status ==
      {$past(backward_data_bit), $past(bit_field_status[NFIELD-1:1])};
  endproperty
  a_bb: assert property (p_bb) else $error("backward bit shift wrong");
  property p_fw;
    go && fe && fmt_q |=> word_field_out ==
      {$past(word_field_out[NFIELD-2:0]), $past(forward_word_in)};
  endproperty
  a_fw: assert property (p_fw) else $error("forward word shift wrong");
  property p_bw;
    go && be && fmt_q |=> word_field_out ==
      {$past(backward_word_in), $past(word_field_out[NFIELD-1:1])};
  endproperty
  a_bw: assert property (p_bw) else $error("backward word shift wrong");
  property p_clr;
    block_enable_coil && clear_coil |=> bit_field_status == '0 && word_field_out == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("clear left data");
  property p_hold;
    !(block_enable_coil && clear_coil) && !go && !wr |=>
      $stable(bit_field_status) && $stable(word_field_out);
  endproperty
  a_hold: assert property (p_hold) else $error("fields moved without cause");
  property p_idle;
    !fmt_q |-> word_field_out == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("word outputs live in bit format");
  property p_cont;
    fmt_q |-> bit_field_status == '0;
  endproperty
  a_cont: assert property (p_cont) else $error("contacts live in word format");
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no answer after setup");
endmodule

// ### testbench/srbd_coil_ctrl.sv
`timescale 1ns/1ps

// Controlling logic on the coil side. Data lines are inverted once the
// pulse drops, so a late sample by the block cannot pass by luck.
module srbd_coil_ctrl (
  input  wire logic        pclk,
  output logic             block_enable_coil,
  output logic             forward_pulse_coil,
  output logic             backward_pulse_coil,
  output logic             clear_coil,
  output logic             forward_data_bit,
  output logic             backward_data_bit,
  output logic [31:0]      forward_word_in,
  output logic [31:0]      backward_word_in
);
  initial begin
    block_enable_coil = 1'h0;
    forward_pulse_coil = 1'h0;
    backward_pulse_coil = 1'h0;
    clear_coil = 1'h0;
    forward_data_bit = 1'h0;
    backward_data_bit = 1'h0;
    forward_word_in = 32'h0000_0000;
    backward_word_in = 32'h0000_0000;
  end

  task automatic set_en(input logic v);
    @(posedge pclk);
    block_enable_coil <= v;
  endtask

  task automatic pulse(input logic f, b, c, input int n, input logic [31:0] wf, wb);
    @(posedge pclk);
    forward_pulse_coil <= f;
    backward_pulse_coil <= b;
    clear_coil <= c;
    forward_data_bit <= wf[0];
    backward_data_bit <= wb[0];
    forward_word_in <= wf;
    backward_word_in <= wb;
    repeat (n) @(posedge pclk);
    forward_pulse_coil <= 1'h0;
    backward_pulse_coil <= 1'h0;
    clear_coil <= 1'h0;
    forward_data_bit <= ~wf[0];
    backward_data_bit <= ~wb[0];
    forward_word_in <= ~wf;
    backward_word_in <= ~wb;
    @(posedge pclk);
  endtask
endmodule

// ### testbench/srbd_shift_register_test.sv
`timescale 1ns/1ps

module srbd_shift_register_test;
  import srbd_pkg::*;

  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, e, fmt, en;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata, r;
  logic             block_enable_coil, forward_pulse_coil, backward_pulse_coil, clear_coil;
  logic             forward_data_bit, backward_data_bit;
  logic [31:0]      forward_word_in, backward_word_in;
  logic [7:0]       bit_field_status, eb;
  logic [7:0][31:0] word_field_out, ew;
  int               errors, checks_done, ns;

  srbd_shift_register DUT (.*);
  srbd_coil_ctrl u_ctrl (.*);

  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [255:0] s, input logic [255:0] x);
    checks_done++;
    if (s !== x) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic chkr(input logic [31:0] x);
    chk(256'(r), 256'(x));
    chk(256'(e), 256'(1'h0));
  endtask

  // ****************************************
  // Bus and coil sequences
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'h1 && i < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      errors++;
      give_verdict;
    end
  endtask

  task automatic bad(input logic w, input logic [11:0] a);
    apb(w, a, 32'hFFFF_FFFF);
    chk(256'(e), 256'(1'h1));
  endtask

  task automatic step(input logic f, b, c, input int n, input logic [31:0] wf, wb);
    u_ctrl.pulse(f, b, c, n, wf, wb);
    if (en && c) begin
      eb = 8'h00;
      ew = '0;
    end else if (en && (f ^ b)) begin
      ns++;
      if (fmt) begin
        ew = f ? {ew[6:0], wf} : {wb, ew[7:1]};
      end else begin
        eb = f ? {eb[6:0], wf[0]} : {wb[0], eb[7:1]};
      end
    end
    @(negedge pclk);
    chk(256'(bit_field_status), 256'(eb));
    chk(word_field_out, ew);
  endtask

  initial begin
    {errors, checks_done, ns} = '0;
    {fmt, en, eb, ew} = '0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CTRL_OFFSET, 32'h0000_0000);
    chkr(32'h0000_0000);
    bad(1'h0, 12'h100);
    bad(1'h1, STATUS_OFFSET);
    bad(1'h1, SHIFT_CNT_OFFSET);
    bad(1'h1, WORD_BASE_OFFSET);
    bad(1'h0, WORD_BASE_OFFSET + 12'h002);
    step(1'h1, 1'h0, 1'h0, 1, 32'h0000_0001, 32'h0000_0001);
    u_ctrl.set_en(1'h1);
    en = 1'h1;
    for (int i = 0; i < 10; i++) begin
      step(1'h1, 1'h0, 1'h0, 1 + i % 3, 32'(i * 5 + i / 2), 32'hFFFF_FFFF);
    end
    for (int i = 0; i < 10; i++) begin
      step(1'h0, 1'h1, 1'h0, 1 + i % 2, 32'hFFFF_FFFF, 32'(i * 3 + i / 3));
    end
    step(1'h1, 1'h1, 1'h0, 1, 32'h0000_0001, 32'h0000_0000);
    apb(1'h0, STATUS_OFFSET, 32'h0000_0000);
    chkr({22'h00_0000, 1'h0, 1'h1, eb});
    u_ctrl.set_en(1'h0);
    en = 1'h0;
    step(1'h0, 1'h0, 1'h1, 1, 32'h0000_0000, 32'h0000_0000);
    u_ctrl.set_en(1'h1);
    en = 1'h1;
    step(1'h1, 1'h0, 1'h1, 2, 32'h0000_0001, 32'h0000_0000);
    step(1'h1, 1'h0, 1'h0, 1, 32'h0000_0001, 32'h0000_0000);
    apb(1'h1, CTRL_OFFSET, 32'h0000_0001);
    fmt = 1'h1;
    eb = 8'h00;
    apb(1'h0, CTRL_OFFSET, 32'h0000_0000);
    chkr(32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      step(1'h1, 1'h0, 1'h0, 1, 32'h8000_0000 + 32'(i) * 32'h1357_9BDF, 32'h0000_0000);
    end
    step(1'h1, 1'h0, 1'h0, 1, 32'h7FFF_FFFF, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      apb(1'h0, WORD_BASE_OFFSET + 12'(4 * k), 32'h0000_0000);
      chkr(ew[k]);
    end
    for (int i = 0; i < 9; i++) begin
      step(1'h0, 1'h1, 1'h0, 2, 32'h0000_0000, 32'h7FFF_FFFF - 32'(i) * 32'h0246_8ACE);
    end
    step(1'h1, 1'h1, 1'h0, 1, 32'h0000_0005, 32'h0000_0006);
    step(1'h0, 1'h0, 1'h1, 1, 32'h0000_0000, 32'h0000_0000);
    step(1'h1, 1'h0, 1'h0, 1, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'h1, CTRL_OFFSET, 32'h0000_0000);
    fmt = 1'h0;
    ew = '0;
    step(1'h1, 1'h0, 1'h0, 1, 32'h1234_5677, 32'h0000_0001);
    apb(1'h0, SHIFT_CNT_OFFSET, 32'h0000_0000);
    chkr({16'h0000, ns[15:0]});
    give_verdict;
  end
endmodule

bind srbd_shift_register srbd_shift_register_monitor #(.NFIELD(NFIELD), .WWIDTH(WWIDTH)) u_mon (.*);
